// ---- hdl/frc_map.svh ----
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH

// Register byte offsets
`define FRC_CTRL_OFS      8'h00
`define FRC_STATUS_OFS    8'h04
`define FRC_PTRS_OFS      8'h08
`define FRC_INT_STAT_OFS  8'h0c
`define FRC_INT_CLR_OFS   8'h10
`define FRC_INT_EN_OFS    8'h14

// Control fields
`define FRC_CTRL_CLEAR    0
`define FRC_CTRL_RST      2'h0

// Status fields
`define FRC_ST_FULL       0
`define FRC_ST_EMPTY      1
`define FRC_ST_HALF       2
`define FRC_ST_ALMOST     3
`define FRC_ST_COUNT_LO   8

// Pointer register fields
`define FRC_PTR_WR_LO     0
`define FRC_PTR_RD_LO     16

// Interrupt event bits
`define FRC_EV_FULL       0
`define FRC_EV_EMPTY      1
`define FRC_EV_ALMOST     2
`define FRC_EV_REFUSED    3
`define FRC_EV_W          4

// Flags out of reset: empty and almost
`define FRC_FLAGS_RST     4'ha

// Flag thresholds and depth range
`define FRC_ALMOST_TH     17'h00010
`define FRC_MIN_DEPTH     17'h00200

// AXI responses
`define FRC_RESP_OKAY     2'b00
`define FRC_RESP_SLVERR   2'b10

`endif

// ---- hdl/frc_pkg.sv ----
package frc_pkg;

	// RAM access sequencer states
	typedef enum logic [2:0] {
		FRC_IDLE   = 3'b000,
		FRC_WLATCH = 3'b001,
		FRC_WRITE  = 3'b010,
		FRC_RFETCH = 3'b011,
		FRC_RLATCH = 3'b100
	} frc_state_type;

endpackage

// ---- hdl/frc_fifo_ram_ctrl.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "frc_map.svh"

module frc_fifo_ram_ctrl #(
	parameter int ADDR_W = 16,
	parameter int SEL_W  = 3
) (
	// Clock and reset
	input  logic                ref_clk,
	input  logic                arst_n,
	// AXI4-Lite write address and data
	input  logic [7:0]          s_axi_awaddr,
	input  logic                s_axi_awvalid,
	output logic                s_axi_awready,
	input  logic [31:0]         s_axi_wdata,
	input  logic [3:0]          s_axi_wstrb,
	input  logic                s_axi_wvalid,
	output logic                s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  logic                s_axi_bready,
	// AXI4-Lite read
	input  logic [7:0]          s_axi_araddr,
	input  logic                s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  logic                s_axi_rready,
	// Asynchronous writer side
	input  logic                put_request_in,
	output logic                put_ack_out,
	output logic                input_latch_strobe,
	// Asynchronous reader side
	input  logic                get_request_in,
	output logic                get_ack_out,
	output logic                output_latch_strobe,
	// Buffer control pins
	input  logic                buffer_clear_in,
	input  logic [SEL_W-1:0]    size_sel_in,
	input  logic                write_enable_in,
	input  logic                read_enable_in,
	// External RAM array
	output logic [ADDR_W-1:0]   ram_addr_out,
	output logic                ram_addr_oe,
	output logic                ram_we_n_out,
	output logic                ram_oe_n_out,
	// Status flags and interrupt
	output logic                full_out,
	output logic                empty_out,
	output logic                half_full_out,
	output logic                almost_out,
	output logic                irq_out
);

	localparam int CW = ADDR_W + 1;

	// depths 512 to 65,536
	// Depth for a size code, 512 words doubling per step
	function automatic logic [CW-1:0] depth_of(input logic [SEL_W-1:0] sel);
		depth_of = CW'(`FRC_MIN_DEPTH << sel);
	endfunction

	// Next pointer value with wrap at the selected depth
	function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p,
		input logic [CW-1:0] d);
		ptr_inc = ({1'b0, p} == d - CW'(1)) ? '0 : p + ADDR_W'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0]             put_sync_reg;
	logic [1:0]             get_sync_reg;
	logic [1:0]             clr_sync_reg;
	logic [1:0]             wen_sync_reg;
	logic [1:0]             ren_sync_reg;
	logic [SEL_W-1:0]       sel_meta_reg;
	logic [SEL_W-1:0]       sel_reg;

	// Two stages each; only the second stage is read below
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			put_sync_reg <= 2'h0;
			get_sync_reg <= 2'h0;
			clr_sync_reg <= 2'h0;
			wen_sync_reg <= 2'h0;
			ren_sync_reg <= 2'h0;
			sel_meta_reg <= '0;
			sel_reg      <= '0;
		end
		else
		begin
			put_sync_reg <= {put_sync_reg[0], put_request_in};
			get_sync_reg <= {get_sync_reg[0], get_request_in};
			clr_sync_reg <= {clr_sync_reg[0], buffer_clear_in};
			wen_sync_reg <= {wen_sync_reg[0], write_enable_in};
			ren_sync_reg <= {ren_sync_reg[0], read_enable_in};
			sel_meta_reg <= size_sel_in;
			sel_reg      <= sel_meta_reg;
		end
	end

	wire put_req = put_sync_reg[1];
	wire get_req = get_sync_reg[1];
	wire wen     = wen_sync_reg[1];
	wire ren     = ren_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Register bus decode

	logic [7:0]             aw_addr_reg;
	logic                   aw_held_reg;
	logic [31:0]            w_data_reg;
	logic [3:0]             w_strb_reg;
	logic                   w_held_reg;
	logic                   bvalid_reg;
	logic [1:0]             bresp_reg;
	logic                   rvalid_reg;
	logic [1:0]             rresp_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             ctrl_reg;
	logic [`FRC_EV_W-1:0]   int_stat_reg;
	logic [`FRC_EV_W-1:0]   int_en_reg;

	// A write fires once both address and data are held
	wire wr_fire    = aw_held_reg && w_held_reg && !bvalid_reg;
	wire wr_ctrl    = wr_fire && (aw_addr_reg == `FRC_CTRL_OFS);
	wire wr_clr     = wr_fire && (aw_addr_reg == `FRC_INT_CLR_OFS);
	wire wr_en      = wr_fire && (aw_addr_reg == `FRC_INT_EN_OFS);
	wire wr_ro      = (aw_addr_reg == `FRC_STATUS_OFS) || (aw_addr_reg == `FRC_PTRS_OFS)
		|| (aw_addr_reg == `FRC_INT_STAT_OFS);
	wire wr_hit     = wr_ctrl || wr_clr || wr_en || (wr_fire && wr_ro);
	wire soft_clear = wr_ctrl && w_strb_reg[0] && w_data_reg[`FRC_CTRL_CLEAR];
	wire [`FRC_EV_W-1:0] clr_bits = wr_clr && w_strb_reg[0] ? w_data_reg[`FRC_EV_W-1:0] : '0;

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	// Address and data are caught separately, in either order
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_addr_reg <= 8'h00;
			aw_held_reg <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `FRC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_reg)
			begin
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid && !w_held_reg)
			begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_held_reg <= 1'b1;
			end
			if (wr_fire)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	// Software-written control and interrupt enable
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg   <= `FRC_CTRL_RST;
			int_en_reg <= '0;
		end
		else
		begin
			if (wr_ctrl && w_strb_reg[0])
				ctrl_reg <= w_data_reg[1:0];
			if (wr_en && w_strb_reg[0])
				int_en_reg <= w_data_reg[`FRC_EV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Occupancy and pointers

	frc_pkg::frc_state_type state_reg;
	frc_pkg::frc_state_type state_next;
	logic [ADDR_W-1:0]      wptr_reg;
	logic [ADDR_W-1:0]      rptr_reg;
	logic [CW-1:0]          count_reg;
	logic [CW-1:0]          count_next;
	logic                   put_ack_reg;
	logic                   get_ack_reg;
	logic                   wr_pend_reg;
	logic                   rd_pend_reg;
	logic                   last_wr_reg;
	logic [3:0]             flags_reg;

	wire [CW-1:0] depth   = depth_of(sel_reg);
	wire          clear   = clr_sync_reg[1] || soft_clear;
	wire          done_wr = (state_reg == frc_pkg::FRC_WRITE);
	wire          done_rd = (state_reg == frc_pkg::FRC_RLATCH);
	wire          is_full = (count_reg >= depth);
	wire          is_empty = (count_reg == '0);

	wire put_take = put_req && !put_ack_reg && !is_full;
	wire get_take = get_req && !get_ack_reg && !is_empty;
	wire put_bad  = put_req && !put_ack_reg && is_full;

	assign count_next = clear ? '0 : done_wr ? count_reg + CW'(1)
		: done_rd ? count_reg - CW'(1) : count_reg;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end
		else if (clear)
		begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end
		else
		begin
			count_reg <= count_next;
			// advance after use, wrap at depth
			if (done_wr)
				wptr_reg <= ptr_inc(wptr_reg, depth);
			if (done_rd)
				rptr_reg <= ptr_inc(rptr_reg, depth);
		end
	end

	// almost flag, half flag, empty flag, full flag
	wire [3:0] flags_next = {
		(count_next <= `FRC_ALMOST_TH) || (depth - count_next <= `FRC_ALMOST_TH),
		count_next >= (depth >> 1),
		count_next == '0,
		count_next >= depth};

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			flags_reg <= `FRC_FLAGS_RST;  // Matches an empty buffer, no false edge
		else
			flags_reg <= flags_next;
	end

	assign full_out      = flags_reg[`FRC_ST_FULL];
	assign empty_out     = flags_reg[`FRC_ST_EMPTY];
	assign half_full_out = flags_reg[`FRC_ST_HALF];
	assign almost_out    = flags_reg[`FRC_ST_ALMOST];

	////////////////////////////////////////////////////////////////////////////////
	// Request acceptance and arbitration

	// ack low on accept, ack before service
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			put_ack_reg <= 1'b0;
			get_ack_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
		end
		else if (clear)
		begin
			put_ack_reg <= 1'b0;
			get_ack_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
		end
		else
		begin
			if (put_take)
				put_ack_reg <= 1'b1;
			else if (!put_req && !wr_pend_reg)
				put_ack_reg <= 1'b0;
			if (get_take)
				get_ack_reg <= 1'b1;
			else if (!get_req && !rd_pend_reg)
				get_ack_reg <= 1'b0;
			wr_pend_reg <= put_take || (wr_pend_reg && !done_wr);
			rd_pend_reg <= get_take || (rd_pend_reg && !done_rd);
		end
	end

	// Low level means acknowledged
	assign put_ack_out = !put_ack_reg;
	assign get_ack_out = !get_ack_reg;

	// Alternate when both wait, so neither side starves
	wire go_wr = wr_pend_reg && wen && (!rd_pend_reg || !ren || !last_wr_reg);
	wire go_rd = rd_pend_reg && ren && !go_wr;

	////////////////////////////////////////////////////////////////////////////////
	// RAM access sequencer

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			frc_pkg::FRC_IDLE:
				if (go_wr)
					state_next = frc_pkg::FRC_WLATCH;
				else if (go_rd)
					state_next = frc_pkg::FRC_RFETCH;
			frc_pkg::FRC_WLATCH:
				state_next = frc_pkg::FRC_WRITE;
			frc_pkg::FRC_RFETCH:
				state_next = frc_pkg::FRC_RLATCH;
			default:
				state_next = frc_pkg::FRC_IDLE;
		endcase
		if (clear)
			state_next = frc_pkg::FRC_IDLE;
	end

	// latch then write, fetch then latch
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg           <= frc_pkg::FRC_IDLE;
			last_wr_reg         <= 1'b0;
			input_latch_strobe  <= 1'b0;
			output_latch_strobe <= 1'b0;
			ram_we_n_out        <= 1'b1;
			ram_oe_n_out        <= 1'b1;
			ram_addr_out        <= '0;
		end
		else
		begin
			state_reg           <= state_next;
			input_latch_strobe  <= (state_next == frc_pkg::FRC_WLATCH);
			output_latch_strobe <= (state_next == frc_pkg::FRC_RLATCH);
			ram_we_n_out        <= (state_next != frc_pkg::FRC_WRITE);
			ram_oe_n_out        <= !(state_next == frc_pkg::FRC_RFETCH
				|| state_next == frc_pkg::FRC_RLATCH);
			// address from the pointer in use
			if (state_next == frc_pkg::FRC_WLATCH)
				ram_addr_out <= wptr_reg;
			else if (state_next == frc_pkg::FRC_RFETCH)
				ram_addr_out <= rptr_reg;
			if (state_reg == frc_pkg::FRC_IDLE && state_next != frc_pkg::FRC_IDLE)
				last_wr_reg <= go_wr;
		end
	end

	// release address bus when both enables low
	assign ram_addr_oe = wen || ren;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	wire [`FRC_EV_W-1:0] events = {
		put_bad,
		flags_next[`FRC_ST_ALMOST] && !flags_reg[`FRC_ST_ALMOST],
		flags_next[`FRC_ST_EMPTY] && !flags_reg[`FRC_ST_EMPTY],
		flags_next[`FRC_ST_FULL] && !flags_reg[`FRC_ST_FULL]};

	// Set wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			int_stat_reg <= '0;
		else
			int_stat_reg <= (int_stat_reg & ~clr_bits) | events;
	end

	assign irq_out = |(int_stat_reg & int_en_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Register read path

	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire rd_hit = (ra == `FRC_CTRL_OFS) || (ra == `FRC_STATUS_OFS) || (ra == `FRC_PTRS_OFS)
		|| (ra == `FRC_INT_STAT_OFS) || (ra == `FRC_INT_CLR_OFS) || (ra == `FRC_INT_EN_OFS);
	wire [31:0] rd_mux =
		(ra == `FRC_CTRL_OFS)     ? {30'h0, ctrl_reg} :
		(ra == `FRC_STATUS_OFS)   ? {(24 - CW)'(0), count_reg, 4'h0, flags_reg} :
		(ra == `FRC_PTRS_OFS)     ? {rptr_reg, wptr_reg} :
		(ra == `FRC_INT_STAT_OFS) ? {(32 - `FRC_EV_W)'(0), int_stat_reg} :
		(ra == `FRC_INT_EN_OFS)   ? {(32 - `FRC_EV_W)'(0), int_en_reg} : 32'h0000_0000;

	// One-cycle read answer; unmapped reads give an error
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `FRC_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_hit ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
			rdata_reg  <= rd_mux;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
	end

endmodule // frc_fifo_ram_ctrl

// ---- test/frc_checker.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Pin-level watcher of the controller
module frc_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Writer and reader handshakes
	input wire logic put_request_in,
	input wire logic put_ack_out,
	input wire logic input_latch_strobe,
	input wire logic get_ack_out,
	input wire logic output_latch_strobe,
	// Control pins
	input wire logic buffer_clear_in,
	input wire logic write_enable_in,
	input wire logic read_enable_in,
	// RAM side
	input wire logic ram_addr_oe,
	input wire logic ram_we_n_out,
	input wire logic ram_oe_n_out,
	// Flags
	input wire logic full_out,
	input wire logic empty_out,
	input wire logic half_full_out,
	input wire logic almost_out
);
	// All pins live in the one clock domain
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	property p_ack_cause;
		$fell(put_ack_out) |-> $past(put_request_in, 3);
	endproperty
	a_ack_cause: assert property (p_ack_cause) // ack cause
		else $error("write ack without request");

	property p_wstrobe;
		input_latch_strobe |-> !put_ack_out ##1 (!input_latch_strobe && !ram_we_n_out);
	endproperty
	a_wstrobe: assert property (p_wstrobe) // latch then store
		else $error("write latch not followed by RAM write");

	property p_rstrobe;
		output_latch_strobe |-> !get_ack_out && !ram_oe_n_out && $past(ram_oe_n_out) == 1'b0;
	endproperty
	a_rstrobe: assert property (p_rstrobe) // fetch then latch
		else $error("read latch without RAM fetch");

	property p_one_access;
		ram_we_n_out || ram_oe_n_out;
	endproperty
	a_one_access: assert property (p_one_access) // single port
		else $error("RAM read and write together");

	property p_full_block;
		full_out && put_ack_out |=> put_ack_out;
	endproperty
	a_full_block: assert property (p_full_block) // no write ack
		else $error("write acknowledged while full");

	property p_empty_block;
		empty_out && get_ack_out |=> get_ack_out && !output_latch_strobe;
	endproperty
	a_empty_block: assert property (p_empty_block) // read blocked
		else $error("read served while empty");

	property p_clear;
		buffer_clear_in [*3] |=> empty_out && !full_out;
	endproperty
	a_clear: assert property (p_clear) // clear empties
		else $error("clear did not empty the buffer");

	property p_hiz;
		(!write_enable_in && !read_enable_in) [*3] |=> !ram_addr_oe;
	endproperty
	a_hiz: assert property (p_hiz) // address released
		else $error("address driven with both enables low");

	property p_full_flags;
		full_out |-> half_full_out && almost_out && !empty_out;
	endproperty
	a_full_flags: assert property (p_full_flags) // flag set
		else $error("flags disagree when full");

	property p_empty_flags;
		empty_out |-> almost_out && !half_full_out && !full_out;
	endproperty
	a_empty_flags: assert property (p_empty_flags) // almost empty
		else $error("flags disagree when empty");
endmodule // frc_checker

bind frc_fifo_ram_ctrl frc_checker u_chk (
	.ref_clk, .arst_n, .put_request_in, .put_ack_out, .input_latch_strobe,
	.get_ack_out, .output_latch_strobe, .buffer_clear_in, .write_enable_in,
	.read_enable_in, .ram_addr_oe, .ram_we_n_out, .ram_oe_n_out, .full_out,
	.empty_out, .half_full_out, .almost_out
);

// ---- test/frc_ram_model.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Write latch, static RAM and read latch beyond the controller
module frc_ram_model (
	// RAM control
	input wire logic [15:0] addr,
	input wire logic        we_n,
	input wire logic        oe_n,
	// Latch strobes and data
	input wire logic        wr_strobe,
	input wire logic        rd_strobe,
	input wire logic [15:0] din,
	output logic     [15:0] dout
);
	logic [15:0] mem [0:65535];
	logic [15:0] wreg;
	logic [15:0] q;

	// Source word captured on the latch strobe
	always @(posedge wr_strobe)
		wreg <= din;
	// Address is settled a cycle before the write pulse opens
	always @(negedge we_n)
		mem[addr] <= wreg;
	// Released data bus floats away from the last word
	assign q = oe_n ? ~dout : mem[addr];
	// Sink register latches the bus
	always @(posedge rd_strobe)
		dout <= q;
endmodule // frc_ram_model

// ---- test/frc_fifo_ram_ctrl_test.sv ----
`timescale 1ns/100ps
`include "frc_map.svh"
module frc_fifo_ram_ctrl_test;
	logic        ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, put_request_in;
	logic        put_ack_out, input_latch_strobe, get_request_in, get_ack_out;
	logic        output_latch_strobe, buffer_clear_in, write_enable_in;
	logic        read_enable_in, ram_addr_oe, ram_we_n_out, ram_oe_n_out;
	logic        full_out, empty_out, half_full_out, almost_out, irq_out;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  size_sel_in;
	logic [15:0] ram_addr_out, src_word, snk_word;
	wire  [15:0] ram_bus;
	int          err_total, num_checks, cyc, i;

	frc_fifo_ram_ctrl dut (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .put_request_in, .put_ack_out, .input_latch_strobe,
		.get_request_in, .get_ack_out, .output_latch_strobe, .buffer_clear_in,
		.size_sel_in, .write_enable_in, .read_enable_in, .ram_addr_out,
		.ram_addr_oe, .ram_we_n_out, .ram_oe_n_out, .full_out, .empty_out,
		.half_full_out, .almost_out, .irq_out);
	// Pull-ups hold the address lines when released
	assign ram_bus = ram_addr_oe ? ram_addr_out : 16'hffff;
	frc_ram_model ram (.addr(ram_bus), .we_n(ram_we_n_out), .oe_n(ram_oe_n_out),
		.wr_strobe(input_latch_strobe), .rd_strobe(output_latch_strobe),
		.din(src_word), .dout(snk_word));

	////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Write channels released one by one as each is taken
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk(n, e, v);
	endtask
	// Four-phase handshakes: raise, ack low, drop, ack high
	task put(input logic [15:0] d);
		@(posedge ref_clk);
		put_request_in <= 1'b1;
		src_word <= d;
		do @(posedge ref_clk); while (put_ack_out !== 1'b0);
		put_request_in <= 1'b0;
		do @(posedge ref_clk); while (put_ack_out !== 1'b1);
	endtask
	task get(input logic [15:0] e);
		@(posedge ref_clk);
		get_request_in <= 1'b1;
		do @(posedge ref_clk); while (get_ack_out !== 1'b0);
		get_request_in <= 1'b0;
		do @(posedge ref_clk); while (get_ack_out !== 1'b1);
		chk("word out", {16'h0, e}, {16'h0, snk_word});
	endtask
	// A refused request must leave both acks high
	task deny(input logic w);
		@(posedge ref_clk);
		put_request_in <= w;
		get_request_in <= !w;
		repeat (12) @(posedge ref_clk);
		chk("acks", 32'h3, {30'h0, put_ack_out, get_ack_out});
		put_request_in <= 1'b0;
		get_request_in <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task pin(input logic [1:0] e);
		@(posedge ref_clk);
		buffer_clear_in <= e[1];
		write_enable_in <= e[0];
		read_enable_in <= e[0];
		repeat (5) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			end_of_test;
		end
	end

	initial
	begin
		{arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, put_request_in, get_request_in, buffer_clear_in} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, size_sel_in, src_word} = '0;
		{write_enable_in, read_enable_in} = 2'b11;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		rdc("status", `FRC_STATUS_OFS, 32'h0000000a); // empty
		axr(8'h18);
		chk("resp", 32'h2, {30'h0, r});
		axw(`FRC_STATUS_OFS, 32'hffffffff);
		chk("bresp ro", 32'h0, {30'h0, r});
		axw(8'h18, 32'h0);
		chk("bresp bad", 32'h2, {30'h0, r});
		rdc("status ro", `FRC_STATUS_OFS, 32'h0000000a);
		axw(`FRC_INT_CLR_OFS, 32'hf);
		axw(`FRC_INT_EN_OFS, 32'hf);
		rdc("int en", `FRC_INT_EN_OFS, 32'hf);
		rdc("int clr", `FRC_INT_CLR_OFS, 32'h0);
		for (i = 0; i < 3; i++)
			put(16'h1110 + i[15:0]); // handshake
		rdc("status 3", `FRC_STATUS_OFS, 32'h00000308); // not empty
		rdc("ptrs 3", `FRC_PTRS_OFS, 32'h3); // advance
		for (i = 0; i < 3; i++)
			get(16'h1110 + i[15:0]); // read order
		rdc("ptrs", `FRC_PTRS_OFS, 32'h00030003); // pointers
		for (i = 0; i < 512; i++)
			put(i[15:0]);
		rdc("status full", `FRC_STATUS_OFS, 32'h0002000d); // flags
		chk("flag pins", 32'hd, {28'h0, almost_out, half_full_out, empty_out, full_out});
		rdc("ptrs wrap", `FRC_PTRS_OFS, 32'h00030003); // wrap
		deny(1'b1); // full refuses
		rdc("int stat", `FRC_INT_STAT_OFS, 32'hf);
		chk("irq", 32'h1, {31'h0, irq_out});
		axw(`FRC_INT_EN_OFS, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq_out});
		axw(`FRC_INT_CLR_OFS, 32'hf);
		rdc("int cleared", `FRC_INT_STAT_OFS, 32'h0);
		for (i = 0; i < 512; i++)
			get(i[15:0]); // data intact
		deny(1'b0); // empty refuses
		put(16'h00a5);
		fork
			put(16'hbeef); // both served
			get(16'h00a5); // both served
		join
		get(16'hbeef);
		rdc("ptrs 5", `FRC_PTRS_OFS, 32'h00050005);
		put(16'h0001);
		pin(2'b11);
		pin(2'b01);
		rdc("ptrs clr", `FRC_PTRS_OFS, 32'h0); // clear
		put(16'h0002);
		axw(`FRC_CTRL_OFS, 32'h1);
		rdc("ptrs soft", `FRC_PTRS_OFS, 32'h0); // soft clear
		rdc("status soft", `FRC_STATUS_OFS, 32'h0000000a); // soft clear
		size_sel_in <= 3'h1;
		for (i = 0; i < 512; i++)
			put(i[15:0]);
		rdc("status half", `FRC_STATUS_OFS, 32'h00020004); // half of 1024
		chk("half pins", 32'h4, {28'h0, almost_out, half_full_out, empty_out, full_out});
		pin(2'b00);
		chk("addr oe", 32'h0, {31'h0, ram_addr_oe}); // released
		end_of_test;
	end
endmodule // frc_fifo_ram_ctrl_test
